// ---- rtl/adcc_top.sv ----
// converter control: sfr registers, start/done sequencing, pin assignment
//
// Contract
// - writing start bit one begins a conversion
// - start bit stays high until conversion completes
// - done flag sets with result; software clears
// - interrupt while done flag and enable set
// - select field picks input zero to seven
// - core result passed unchanged: full scale 3FF
// - converter clock is cpu divided by prescaler
// - power bit zero puts converter in standby
// - pseudo idle halts cpu during conversion
// - pin assign bit one makes pin analog
// - reserved bits read zero, software writes zero
// - conversion lasts eleven converter clocks
// - only done interrupt wakes pseudo idle
// - start ignored on non-analog selected pin
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_top
    import adcc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire adcc_sfr_req_type sfr_req,
    output logic [7:0]            sfr_rdata,
    input  wire logic             conv_irq_enable,
    input  wire logic             global_irq_enable,
    input  wire logic             double_speed_mode,
    input  wire logic [9:0]       converter_result,
    input  wire logic             other_irq_pending,
    output logic [2:0]            converter_input,
    output logic                  converter_power,
    output logic                  converter_sample,
    output logic                  converter_convert,
    output logic [7:0]            pin_analog_select_bits,
    output logic                  cpu_halt,
    output logic                  conv_irq,
    output logic                  other_irq_release,
    output logic                  setup_done
);
    adcc_control_type control_q;
    adcc_control_type control_d;
    adcc_state_type   state_q;
    adcc_state_type   state_d;
    logic [4:0]       clock_divide_field_q;
    logic [4:0]       clock_divide_field_d;
    logic [7:0]       pin_assign_q;
    logic [7:0]       pin_assign_d;
    logic [7:0]       result_high_q;
    logic [7:0]       result_high_d;
    logic [1:0]       result_low_q;
    logic [1:0]       result_low_d;
    logic [3:0]       tick_count_q;
    logic [3:0]       tick_count_d;
    logic             idle_run_q;
    logic             idle_run_d;
    logic [8:0]       setup_count_q;
    logic [8:0]       setup_count_d;
    logic [7:0]       rdata_q;
    logic [7:0]       rdata_d;
    logic             tick;
    logic             wr_control;
    logic             start_req;
    logic             finish;

    adcc_divider u_divider (
        .clk                (clk),
        .rstn               (rstn),
        .run                (state_q != ADCC_IDLE),
        .double_speed_mode  (double_speed_mode),
        .clock_divide_field (clock_divide_field_q),
        .tick               (tick)
    );

    assign wr_control = sfr_req.write_en
                        && sfr_req.addr == `ADCC_OFS_CONTROL;
    // a start on a pin still in digital use is dropped
    assign start_req = wr_control && sfr_req.wdata[`ADCC_BIT_START]
                       && control_q.power
                       && pin_assign_q[sfr_req.wdata[2:0]];
    // sample-and-hold tick plus ten bit ticks
    assign finish = state_q == ADCC_CONVERT && tick
                    && tick_count_q == `ADCC_CONV_CYCLES - 4'h1;

    always_comb begin
        control_d            = control_q;
        clock_divide_field_d = clock_divide_field_q;
        pin_assign_d         = pin_assign_q;
        result_high_d        = result_high_q;
        result_low_d         = result_low_q;
        idle_run_d           = idle_run_q;
        if (sfr_req.write_en) begin
            if (sfr_req.addr == `ADCC_OFS_CLKDIV) begin
                clock_divide_field_d = sfr_req.wdata[4:0];
            end else if (sfr_req.addr == `ADCC_OFS_PIN_ASGN) begin
                pin_assign_d = sfr_req.wdata;
            end
        end
        if (wr_control) begin
            control_d.input_select = sfr_req.wdata[2:0];
            control_d.power = sfr_req.wdata[`ADCC_BIT_POWER];
            control_d.pseudo_idle = sfr_req.wdata[`ADCC_BIT_PIDLE];
            // done flag: software may only clear it
            if (!sfr_req.wdata[`ADCC_BIT_DONE]) begin
                control_d.done = 1'b0;
            end
        end
        if (start_req && state_q == ADCC_IDLE) begin
            control_d.start = 1'b1;
            idle_run_d = sfr_req.wdata[`ADCC_BIT_PIDLE];
        end
        if (finish) begin
            // set wins over a same-cycle software clear
            control_d.start = 1'b0;
            control_d.done  = 1'b1;
            idle_run_d      = 1'b0;
            result_high_d   = converter_result[9:2];
            result_low_d    = converter_result[1:0];
        end
        // standby drops a running conversion, so neither the busy bit
        // nor the cpu halt may be left stuck high
        if (!control_d.power) begin
            control_d.start = 1'b0;
            idle_run_d      = 1'b0;
        end
    end

    always_comb begin
        state_d      = state_q;
        tick_count_d = tick_count_q;
        case (state_q)
            ADCC_IDLE: begin
                tick_count_d = 4'h0;
                if (start_req) begin
                    state_d = ADCC_SAMPLE;
                end
            end
            ADCC_SAMPLE: begin
                if (tick) begin
                    tick_count_d = 4'h1;
                    state_d      = ADCC_CONVERT;
                end
            end
            ADCC_CONVERT: begin
                if (finish) begin
                    state_d = ADCC_IDLE;
                end else if (tick) begin
                    tick_count_d = 4'(tick_count_q + 4'h1);
                end
            end
            default: begin
                state_d = ADCC_IDLE;
            end
        endcase
        // standby aborts a running conversion
        if (!control_d.power) begin
            state_d = ADCC_IDLE;
        end
    end

    always_comb begin
        setup_count_d = setup_count_q;
        if (!control_q.power) begin
            setup_count_d = 9'h000;
        end else if (setup_count_q != 9'(`ADCC_SETUP_CYCLES)) begin
            setup_count_d = 9'(setup_count_q + 9'h001);
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (sfr_req.read_en) begin
            // reserved bits read as zero
            if (sfr_req.addr == `ADCC_OFS_CLKDIV) begin
                rdata_d = {3'h0, clock_divide_field_q};
            end else if (sfr_req.addr == `ADCC_OFS_CONTROL) begin
                rdata_d = {1'b0, control_q};
            end else if (sfr_req.addr == `ADCC_OFS_RES_LOW) begin
                rdata_d = {6'h00, result_low_q};
            end else if (sfr_req.addr == `ADCC_OFS_RES_HIGH) begin
                rdata_d = result_high_q;
            end else if (sfr_req.addr == `ADCC_OFS_PIN_ASGN) begin
                rdata_d = pin_assign_q;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            control_q            <= adcc_control_type'(7'(`ADCC_RST_BYTE));
            state_q              <= ADCC_IDLE;
            clock_divide_field_q <= 5'h00;
            pin_assign_q         <= `ADCC_RST_BYTE;
            result_high_q        <= `ADCC_RST_BYTE;
            result_low_q         <= 2'h0;
            tick_count_q         <= 4'h0;
            idle_run_q           <= 1'b0;
            setup_count_q        <= 9'h000;
            rdata_q              <= `ADCC_RST_BYTE;
        end else begin
            control_q            <= control_d;
            state_q              <= state_d;
            clock_divide_field_q <= clock_divide_field_d;
            pin_assign_q         <= pin_assign_d;
            result_high_q        <= result_high_d;
            result_low_q         <= result_low_d;
            tick_count_q         <= tick_count_d;
            idle_run_q           <= idle_run_d;
            setup_count_q        <= setup_count_d;
            rdata_q              <= rdata_d;
        end
    end

    assign sfr_rdata              = rdata_q;
    assign converter_input        = control_q.input_select;
    assign converter_power        = control_q.power;
    assign converter_sample       = state_q == ADCC_SAMPLE;
    assign converter_convert      = state_q == ADCC_CONVERT;
    assign pin_analog_select_bits = pin_assign_q;
    assign cpu_halt               = idle_run_q;
    assign conv_irq = control_q.done && conv_irq_enable && global_irq_enable;
    // other sources held off while pseudo idle runs
    assign other_irq_release      = other_irq_pending && !idle_run_q;
    assign setup_done = setup_count_q == 9'(`ADCC_SETUP_CYCLES);
endmodule

// ---- rtl/adcc_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH
`define ADCC_OFS_CLKDIV    8'hF2
`define ADCC_OFS_CONTROL   8'hF3
`define ADCC_OFS_RES_LOW   8'hF4
`define ADCC_OFS_RES_HIGH  8'hF5
`define ADCC_OFS_PIN_ASGN  8'hF6
`define ADCC_BIT_START     3
`define ADCC_BIT_DONE      4
`define ADCC_BIT_POWER     5
`define ADCC_BIT_PIDLE     6
`define ADCC_RST_BYTE      8'h00
`define ADCC_CONV_CYCLES   4'hB
`define ADCC_SETUP_NS      4000
`define ADCC_CLK_NS        10
`define ADCC_SETUP_CYCLES  ((`ADCC_SETUP_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`endif

// ---- rtl/adcc_pkg.sv ----
// types shared by the converter control block
package adcc_pkg;
    typedef enum logic [2:0] {
        ADCC_IDLE = 3'b001,
        ADCC_SAMPLE = 3'b010,
        ADCC_CONVERT = 3'b100
    } adcc_state_type;

    typedef struct packed {
        logic       pseudo_idle;
        logic       power;
        logic       done;
        logic       start;
        logic [2:0] input_select;
    } adcc_control_type;

    typedef struct packed {
        logic       write_en;
        logic       read_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adcc_sfr_req_type;
endpackage

// ---- rtl/adcc_divider.sv ----
// converter clock tick generator: cpu clock / (2 or 4 * (divide + 1))
`timescale 1ns/1ps
module adcc_divider
    import adcc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic       double_speed_mode,
    input  wire logic [4:0] clock_divide_field,
    output logic            tick
);
    logic [6:0] count_q;
    logic [6:0] count_d;
    logic [6:0] limit;
    logic       tick_d;
    logic       tick_q;

    always_comb begin
        // period minus one, in cpu cycles
        if (double_speed_mode) begin
            limit = 7'({clock_divide_field, 1'b0} + 6'h01);
        end else begin
            limit = 7'({clock_divide_field, 2'b00} + 7'h03);
        end
        tick_d = 1'b0;
        if (!run) begin
            count_d = 7'h00;
        end else if (count_q >= limit) begin
            count_d = 7'h00;
            tick_d  = 1'b1;
        end else begin
            count_d = 7'(count_q + 7'h01);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= 7'h00;
            tick_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            tick_q  <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule

// ---- test/adcc_core_model.sv ----
// analog core stand-in: holds a code derived from the sampled input
`timescale 1ns/1ps
module adcc_core_model (
    input  wire logic       clk,
    input  wire logic       converter_power,
    input  wire logic       converter_sample,
    input  wire logic [2:0] converter_input,
    output logic [9:0]      converter_result
);
    logic [9:0] held  = 10'h000;
    logic [9:0] res_q = 10'h155;
    // in standby no code is valid, so the lines toggle every cycle
    always @(posedge clk) begin
        if (converter_sample) begin
            held <= {converter_input, ~converter_input, 4'h5};
        end
        res_q <= converter_power ? held : ~res_q;
    end
    assign converter_result = res_q;
endmodule

// ---- test/adcc_checker.sv ----
// port-level assertions for the converter control block
`timescale 1ns/1ps
module adcc_checker
    import adcc_pkg::*;
(
    input wire logic             clk,
    input wire logic             rstn,
    input wire adcc_sfr_req_type sfr_req,
    input wire logic [7:0]       sfr_rdata,
    input wire logic             conv_irq_enable,
    input wire logic             global_irq_enable,
    input wire logic             other_irq_pending,
    input wire logic [2:0]       converter_input,
    input wire logic             converter_power,
    input wire logic             converter_sample,
    input wire logic             converter_convert,
    input wire logic [7:0]       pin_analog_select_bits,
    input wire logic             cpu_halt,
    input wire logic             conv_irq,
    input wire logic             other_irq_release,
    input wire logic             setup_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic wr_ctl, idle, go;
    assign wr_ctl = sfr_req.write_en && sfr_req.addr == 8'hF3;
    assign idle = !converter_sample && !converter_convert;
    assign go = wr_ctl && sfr_req.wdata[3] && idle;
    chk_irq_gate: assert property (conv_irq |->
        conv_irq_enable && global_irq_enable) else $error("irq ungated");
    chk_sel_follow: assert property (wr_ctl |=>
        converter_input == $past(sfr_req.wdata[2:0])) else $error("select");
    chk_power_follow: assert property (wr_ctl |=>
        converter_power == $past(sfr_req.wdata[5])) else $error("power");
    chk_pin_follow: assert property (sfr_req.write_en &&
        sfr_req.addr == 8'hF6 |=> pin_analog_select_bits ==
        $past(sfr_req.wdata)) else $error("pin assign");
    chk_wake_gate: assert property (other_irq_release ==
        (other_irq_pending && !cpu_halt)) else $error("wake gate");
    chk_start_taken: assert property (go && sfr_req.wdata[5] &&
        converter_power && pin_analog_select_bits[sfr_req.wdata[2:0]]
        |=> converter_sample) else $error("start lost");
    chk_start_refused: assert property (go &&
        !pin_analog_select_bits[sfr_req.wdata[2:0]] |=> idle)
        else $error("start on digital pin");
    chk_sample_then_conv: assert property ($fell(converter_sample)
        && converter_power |-> converter_convert) else $error("sequence");
    chk_unmapped_zero: assert property (sfr_req.read_en &&
        (sfr_req.addr < 8'hF2 || sfr_req.addr > 8'hF6) |=> sfr_rdata == 8'h00)
        else $error("unmapped read");
    chk_setup_wait: assert property ($rose(converter_power)
        |=> !setup_done [*8]) else $error("setup early");
endmodule

// ---- test/adcc_top_bench.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adcc_top_bench
    import adcc_pkg::*;
;
    logic             clk, rstn, ien, gen, dbl, pend;
    adcc_sfr_req_type sfr_req;
    logic [7:0]       rdata, pins, c, p;
    logic [9:0]       res, e, t;
    logic [2:0]       sel;
    logic             pwr, smp, cnv, halt, irq, rel, sdone;
    int               n_mismatch = 0, tests_run = 0, n;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    adcc_top adcc_top_i (.clk(clk), .rstn(rstn), .sfr_req(sfr_req),
        .sfr_rdata(rdata), .conv_irq_enable(ien), .global_irq_enable(gen),
        .double_speed_mode(dbl), .converter_result(res),
        .other_irq_pending(pend), .converter_input(sel),
        .converter_power(pwr), .converter_sample(smp),
        .converter_convert(cnv), .pin_analog_select_bits(pins),
        .cpu_halt(halt), .conv_irq(irq), .other_irq_release(rel),
        .setup_done(sdone));
    adcc_core_model adcc_core_model_i (.clk(clk), .converter_power(pwr),
        .converter_sample(smp), .converter_input(sel),
        .converter_result(res));

    task automatic chk(input string s, input logic [9:0] x,
                       input logic [9:0] y);
        tests_run++;
        if (y !== x) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", s, x, y);
        end
    endtask
    // one idle cycle follows every access, so strobes are never re-driven
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) sfr_req = '{1'b1, 1'b0, a, d};
        @(negedge clk) sfr_req = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(negedge clk) sfr_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk) sfr_req = '0;
        chk($sformatf("reg %h", a), {2'b00, x}, {2'b00, rdata});
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #200us;
        n_mismatch++;
        close_out;
    end

    initial begin
        rstn = 1'b0;
        sfr_req = '0;
        {ien, gen, dbl, pend} = 4'b0001;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        for (int a = 'hF2; a < 'hF8; a++) rd(8'(a), 8'h00);
        wr(8'hF2, 8'h1F);
        rd(8'hF2, 8'h1F);
        wr(8'hF3, 8'h20);
        // the converter settles before any conversion is asked for
        repeat (400) @(negedge clk);
        chk("setup", 10'h001, 10'(sdone));
        wr(8'hF3, 8'h28);
        rd(8'hF3, 8'h20);
        wr(8'hF6, 8'hFF);
        chk("pins", 10'h0FF, 10'(pins));
        ien = 1'b1;
        for (int ch = 0; ch < 8; ch++) begin
            // channel six runs the slowest converter clock on offer
            p = (ch == 6) ? 8'h1F : 8'(ch % 3);
            wr(8'hF2, p);
            dbl = ch[0];
            c = 8'h28 | 8'(ch) | (ch == 5 ? 8'h40 : 8'h00);
            wr(8'hF3, c);
            chk("sel", 10'(ch), 10'(sel));
            chk("halt", 10'(c[6]), 10'(halt));
            chk("release", 10'(!c[6]), 10'(rel));
            rd(8'hF3, c);
            n = 3;
            while ((smp | cnv) === 1'b1 && n < 2000) begin
                @(negedge clk);
                n++;
            end
            t = 10'(ch[0] ? 2 : 4) * 10'(p + 1);
            chk("cycles", 10'h001,
                10'(n >= 11 * t + 1 && n <= 11 * t + 3));
            e = {3'(ch), ~3'(ch), 4'h5};
            rd(8'hF3, c ^ 8'h18);
            rd(8'hF5, e[9:2]);
            rd(8'hF4, {6'h00, e[1:0]});
            chk("release", 10'h001, 10'(rel));
            chk("irq", 10'h000, 10'(irq));
            gen = 1'b1;
            #1 chk("irq", 10'h001, 10'(irq));
            wr(8'hF3, c ^ 8'h18);
            chk("irq", 10'h001, 10'(irq));
            wr(8'hF3, c & 8'hE7);
            chk("irq", 10'h000, 10'(irq));
            gen = 1'b0;
        end
        pend = 1'b0;
        wr(8'hF3, 8'h68);
        chk("halt", 10'h001, 10'(halt));
        // standby in mid-conversion must free the cpu and the busy bit
        wr(8'hF3, 8'h00);
        chk("power", 10'h000, 10'(pwr));
        chk("halt", 10'h000, 10'(halt));
        chk("busy", 10'h000, 10'(smp | cnv));
        chk("release", 10'h000, 10'(rel));
        rd(8'hF3, 8'h00);
        wr(8'hF3, 8'h20);
        repeat (399) @(negedge clk);
        chk("setup", 10'h000, 10'(sdone));
        @(negedge clk);
        chk("setup", 10'h001, 10'(sdone));
        close_out;
    end
endmodule

bind adcc_top adcc_checker adcc_checker_i (
    .clk                    (clk),
    .rstn                   (rstn),
    .sfr_req                (sfr_req),
    .sfr_rdata              (sfr_rdata),
    .conv_irq_enable        (conv_irq_enable),
    .global_irq_enable      (global_irq_enable),
    .other_irq_pending      (other_irq_pending),
    .converter_input        (converter_input),
    .converter_power        (converter_power),
    .converter_sample       (converter_sample),
    .converter_convert      (converter_convert),
    .pin_analog_select_bits (pin_analog_select_bits),
    .cpu_halt               (cpu_halt),
    .conv_irq               (conv_irq),
    .other_irq_release      (other_irq_release),
    .setup_done             (setup_done)
);
